// ==== design/mft_timer_core.sv ====
`timescale 1ns/100ps
// What this block does
// R1: software picks one-shot with bits 1,2 set
// R2: triggers need start flag; bit4 picks pin
// R3: bit3 picks rising or falling pin edge
// R4: one-shot start bit gives software trigger
// R5: nonzero counter: output high, count down
// R6: at 0001h: low, stop, reload, request
// R7: start flag 0 holds output low
// R8: retrigger while active reloads the counter
// R9: retrigger reloads in the same cycle, not after a count-source cycle
// R10: halted write loads counter; running only reload
// R11: group A read gives undefined data
// R12: bits 0,1,2 set modulate; bit5 picks width
// R13: modulation starts on flag or pin edge
// R14: started modulation ignores further triggers
// R15: 16-bit: m high in 65535 cycles
// R16: request on each output falling edge, none when a cleared start flag forces it low
// R17: reload copied just before next rise
// R18: 8-bit: low byte prescales every n+1
// R19: high byte: (n+1)*m high in (n+1)*255
// R20: group B timer mode counts, reloads, requests
// R21: group B halted write loads counter too
// R22: group B event mode counts chosen pin edges
// R23: start flags clear after reset
module mft_timer_core
#(
   parameter int NUM_A = 5, // group A timers
   parameter int NUM_B = 3  // group B timers
)
(
   input  wire logic                            clk_sys_i,                // system clock
   input  wire logic                            rst_i,                    // async reset, high
   input  wire logic [mft_pkg::NUM_SRC-1:0]     count_tick_i,             // count source pulses
   input  wire logic [NUM_A+NUM_B-1:0]          count_start_i,            // count start flags
   input  wire logic [NUM_A-1:0]                oneshot_start_i,          // one-shot start pulses
   input  wire logic [NUM_A-1:0][7:0]           mode_a_i,                 // group A mode bytes
   input  wire logic [NUM_B-1:0][7:0]           mode_b_i,                 // group B mode bytes
   input  mft_pkg::mft_wr_s [NUM_A-1:0]         wr_a_i,                   // group A writes
   input  mft_pkg::mft_wr_s [NUM_B-1:0]         wr_b_i,                   // group B writes
   input  wire logic [NUM_A-1:0]                group_a_trigger_input_pin_i, // A trigger pins
   input  wire logic [NUM_B-1:0]                group_b_event_input_pin_i,   // B event pins
   output logic      [NUM_A-1:0]                group_a_pulse_output_pin_o,  // A pulse pins
   output logic      [NUM_A-1:0]                irq_a_o,                  // A request pulses
   output logic      [NUM_B-1:0]                irq_b_o,                  // B request pulses
   output logic      [NUM_A-1:0][15:0]          read_a_o,                 // A read data
   output logic      [NUM_B-1:0][15:0]          read_b_o                  // B counter read
);
   import mft_pkg::*;

   // ============================================================
   // start flags, registered so reset clears them
   // ============================================================
   logic [NUM_A+NUM_B-1:0] start_r; // count start flags
   logic [NUM_A-1:0]       osw_r;   // one-shot software trigger

   // flags sampled each edge; reset forces every timer idle
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         start_r <= '0; // R23
         osw_r   <= '0; // R23
      end
      else
      begin
         start_r <= count_start_i;
         osw_r   <= oneshot_start_i;
      end
   end

   // ============================================================
   // group A: one-shot and modulator
   // ============================================================
   genvar ga;
   generate
      for (ga = 0; ga < NUM_A; ga++)
      begin : g_a
         mft_state_e  st_r;        // activity state
         mft_state_e  st_nxt;      // next state
         logic [15:0] reload_r;    // reload register
         logic [15:0] cnt_r;       // main down counter
         logic [15:0] cnt_nxt;     // next counter
         logic [15:0] per_r;       // modulator period position
         logic [15:0] per_nxt;     // next period position
         logic [7:0]  pre_r;       // 8-bit prescaler
         logic [7:0]  pre_nxt;     // next prescaler
         logic        out_r;       // pulse output
         logic        out_nxt;     // next output
         logic        irq_r;       // request pulse
         logic        irq_nxt;     // next request
         logic        pin_d_r;     // previous pin level
         logic [15:0] reload_nxt;  // next reload

         wire [7:0]  mode     = mode_a_i[ga];                     // mode byte
         wire        run_en   = start_r[ga];                      // count start flag
         wire        tick     = count_tick_i[mode[MODE_SRC_HI:MODE_SRC_LO]]; // selected source
         wire        pin      = group_a_trigger_input_pin_i[ga];  // trigger pin level
         wire        rise     = pin & ~pin_d_r;                   // rising pin edge
         wire        fall     = ~pin & pin_d_r;                   // falling pin edge
         wire        pin_trig = mode[MODE_B3] ? rise : fall;      // R3
         wire        os_mode  = ~mode[MODE_B0] & mode[MODE_B1] & mode[MODE_B2]
                                & ~mode[MODE_B5];                 // R1
         wire        pwm_mode = mode[MODE_B0] & mode[MODE_B1] & mode[MODE_B2]; // R12
         wire        is8      = mode[MODE_B5];                    // R12
         // one-shot: pin or start-bit trigger, only while started
         wire        os_trig  = run_en & (mode[MODE_B4] ? pin_trig : osw_r[ga]); // R2 R4
         // modulator: start flag itself, or pin edge while started
         wire        pwm_trig = run_en & (mode[MODE_B4] ? pin_trig : 1'b1);     // R13
         wire        pre_tick = tick & (pre_r == 8'h00);          // R18
         wire        mtick    = is8 ? pre_tick : tick;            // R19
         wire [15:0] per_last = is8 ? PER8_LAST : PER16_LAST;     // R15 R19
         wire [15:0] width    = is8 ? {8'h00, reload_r[15:8]} : reload_r; // R19

         // next-state logic; trigger outranks a count tick
         always_comb
         begin
            st_nxt     = st_r;
            cnt_nxt    = cnt_r;
            per_nxt    = per_r;
            pre_nxt    = pre_r;
            out_nxt    = out_r;
            irq_nxt    = 1'b0;
            reload_nxt = reload_r;
            // software write: counter only follows while halted
            if (wr_a_i[ga].en)
            begin
               reload_nxt = wr_a_i[ga].data;                      // R10 R17
               if (!run_en)
                  cnt_nxt = wr_a_i[ga].data;                      // R10
            end
            if (!run_en)
            begin
               // halted: output forced low, nothing runs
               st_nxt  = MFT_IDLE;                                // R7
               out_nxt = 1'b0;                                    // R7
            end
            else
            begin
               unique case (st_r)
                  MFT_IDLE:
                  begin
                     if (os_mode && os_trig && cnt_r != CNT_ZERO)
                     begin
                        st_nxt  = MFT_ONESHOT;                    // R5
                        out_nxt = 1'b1;                           // R5
                     end
                     else if (pwm_mode && pwm_trig)
                     begin
                        st_nxt  = MFT_PWM;
                        per_nxt = CNT_ZERO;
                        pre_nxt = reload_r[7:0];                  // R18
                        cnt_nxt = width;                          // R17
                        out_nxt = (width != CNT_ZERO);
                     end
                  end
                  MFT_ONESHOT:
                  begin
                     if (os_trig)
                        cnt_nxt = reload_r;                       // R8
                     else if (tick)
                     begin
                        if (cnt_r == CNT_ONE)
                        begin
                           st_nxt  = MFT_IDLE;                    // R6
                           out_nxt = 1'b0;                        // R6
                           cnt_nxt = reload_r;                    // R6
                           irq_nxt = 1'b1;                        // R6
                        end
                        else
                           cnt_nxt = cnt_r - CNT_ONE;             // R5
                     end
                  end
                  MFT_PWM:
                  begin
                     // triggers are not looked at here at all
                     if (tick)                                    // R14
                        pre_nxt = (pre_r == 8'h00) ? reload_r[7:0] : pre_r - 8'h01; // R18
                     if (mtick)
                     begin
                        if (per_r == per_last)
                        begin
                           // period wrap: new width taken just before the rise
                           per_nxt = CNT_ZERO;                    // R15 R19
                           cnt_nxt = width;                       // R17
                           out_nxt = (width != CNT_ZERO);
                           irq_nxt = out_r & (width == CNT_ZERO); // R16
                        end
                        else
                        begin
                           per_nxt = per_r + CNT_ONE;
                           if (out_r)
                           begin
                              cnt_nxt = cnt_r - CNT_ONE;
                              if (cnt_r == CNT_ONE)
                              begin
                                 out_nxt = 1'b0;                  // R15
                                 irq_nxt = 1'b1;                  // R16
                              end
                           end
                        end
                     end
                  end
               endcase
            end
         end

         // state registers of this timer
         always_ff @(posedge clk_sys_i or posedge rst_i)
         begin
            if (rst_i)
            begin
               st_r     <= MFT_IDLE;
               reload_r <= CNT_ZERO;
               cnt_r    <= CNT_ZERO;
               per_r    <= CNT_ZERO;
               pre_r    <= 8'h00;
               out_r    <= 1'b0;
               irq_r    <= 1'b0;
               pin_d_r  <= 1'b0;
            end
            else
            begin
               st_r     <= st_nxt;
               reload_r <= reload_nxt;
               cnt_r    <= cnt_nxt;
               per_r    <= per_nxt;
               pre_r    <= pre_nxt;
               out_r    <= out_nxt;
               irq_r    <= irq_nxt;
               pin_d_r  <= pin;
            end
         end

         // the counter is deliberately not exposed on reads
         assign group_a_pulse_output_pin_o[ga] = out_r;
         assign irq_a_o[ga]                    = irq_r;
         assign read_a_o[ga]                   = READ_UNDEF;      // R11
      end
   endgenerate

   // ============================================================
   // group B: timer and event counter
   // ============================================================
   genvar gb;
   generate
      for (gb = 0; gb < NUM_B; gb++)
      begin : g_b
         logic [15:0] reload_r; // reload register
         logic [15:0] cnt_r;    // down counter
         logic        irq_r;    // request pulse
         logic        pin_d_r;  // previous pin level

         wire [7:0] mode   = mode_b_i[gb];                        // mode byte
         wire       run_en = start_r[NUM_A+gb];                   // count start flag
         wire       pin    = group_b_event_input_pin_i[gb];       // event pin
         wire       rise   = pin & ~pin_d_r;                      // rising edge
         wire       fall   = ~pin & pin_d_r;                      // falling edge
         wire [1:0] esel   = mode[MODE_B3:MODE_B2];               // edge choice
         wire       ev_pin = (esel == EDGE_FALL) ? fall :
                             (esel == EDGE_RISE) ? rise :
                             (esel == EDGE_BOTH) ? (rise | fall) : 1'b0; // R22
         wire       tmr_m  = ~mode[MODE_B0] & ~mode[MODE_B1];     // R20
         wire       evt_m  = mode[MODE_B0] & ~mode[MODE_B1];      // R22
         // measurement modes are not built, so they never count
         wire       ev     = run_en & ((tmr_m & count_tick_i[mode[MODE_SRC_HI:MODE_SRC_LO]])
                                       | (evt_m & ev_pin));       // R20 R22
         wire       wrap   = ev & (cnt_r == CNT_ZERO);            // R20

         // counter, reload and write handling
         always_ff @(posedge clk_sys_i or posedge rst_i)
         begin
            if (rst_i)
            begin
               reload_r <= CNT_ZERO;
               cnt_r    <= CNT_ZERO;
               irq_r    <= 1'b0;
               pin_d_r  <= 1'b0;
            end
            else
            begin
               pin_d_r <= pin;
               irq_r   <= wrap;                                   // R20
               if (wr_b_i[gb].en)
                  reload_r <= wr_b_i[gb].data;                    // R21
               // a halted write wins; a running one waits for reload
               if (wr_b_i[gb].en && !run_en)
                  cnt_r <= wr_b_i[gb].data;                       // R21
               else if (wrap)
                  cnt_r <= reload_r;                              // R20
               else if (ev)
                  cnt_r <= cnt_r - CNT_ONE;                       // R20
            end
         end

         assign irq_b_o[gb]  = irq_r;
         assign read_b_o[gb] = cnt_r;                             // R21
      end
   endgenerate

endmodule

// ==== design/mft_pkg.sv ====
// ============================================================
// shared constants and carriers for the multi-function timers
// ============================================================
package mft_pkg;

   // ============================================================
   // mode byte field positions
   // ============================================================
   localparam int MODE_B0    = 0;  // mode select bit 0
   localparam int MODE_B1    = 1;  // mode select bit 1
   localparam int MODE_B2    = 2;  // pulse output / edge select low
   localparam int MODE_B3    = 3;  // active edge select
   localparam int MODE_B4    = 4;  // pin trigger select
   localparam int MODE_B5    = 5;  // 8-bit modulator select
   localparam int MODE_SRC_LO = 6; // count source select low bit
   localparam int MODE_SRC_HI = 7; // count source select high bit

   // ============================================================
   // counter constants
   // ============================================================
   localparam logic [15:0] CNT_ZERO     = 16'h0000; // empty counter
   localparam logic [15:0] CNT_ONE      = 16'h0001; // one-shot end value
   localparam logic [15:0] PER16_LAST   = 16'hFFFE; // 65535 ticks, 0..65534
   localparam logic [15:0] PER8_LAST    = 16'h00FE; // 255 ticks, 0..254
   localparam logic [15:0] READ_UNDEF   = 16'h0000; // value shown on an undefined read
   localparam logic [7:0]  MODE_RST     = 8'h00;    // mode reset value
   localparam int          NUM_SRC      = 4;        // count source taps

   // ============================================================
   // group B edge choices (bits 3:2)
   // ============================================================
   localparam logic [1:0] EDGE_FALL = 2'h0; // falling edges
   localparam logic [1:0] EDGE_RISE = 2'h1; // rising edges
   localparam logic [1:0] EDGE_BOTH = 2'h2; // both edges

   // group A activity state, one-hot
   typedef enum logic [2:0] {
      MFT_IDLE    = 3'h1, // halted or waiting for a trigger
      MFT_ONESHOT = 3'h2, // one-shot pulse active
      MFT_PWM     = 3'h4  // modulator running
   } mft_state_e;

   // software write to a timer
   typedef struct packed {
      logic        en;   // one-cycle write strobe
      logic [15:0] data; // value written
   } mft_wr_s;

endpackage

// ==== tb/mft_timer_core_sva.sv ====
`timescale 1ns/100ps
// ============================================================
// port checker for timer A0 and timer B0
// ============================================================
module mft_timer_core_sva
   import mft_pkg::*;
#(
   parameter int NUM_A = 5, // group A timers
   parameter int NUM_B = 3  // group B timers
)
(
   input  wire logic                    clk_sys_i,                   // system clock
   input  wire logic                    rst_i,                       // async reset
   input  wire logic [NUM_SRC-1:0]      count_tick_i,                // source taps
   input  wire logic [NUM_A+NUM_B-1:0]  count_start_i,               // start flags
   input  wire logic [NUM_A-1:0]        oneshot_start_i,             // soft triggers
   input  wire logic [NUM_A-1:0][7:0]   mode_a_i,                    // A modes
   input  wire logic [NUM_B-1:0][7:0]   mode_b_i,                    // B modes
   input  mft_wr_s   [NUM_A-1:0]        wr_a_i,                      // A writes
   input  mft_wr_s   [NUM_B-1:0]        wr_b_i,                      // B writes
   input  wire logic [NUM_A-1:0]        group_a_trigger_input_pin_i, // A pins
   input  wire logic [NUM_B-1:0]        group_b_event_input_pin_i,   // B pins
   input  wire logic [NUM_A-1:0]        group_a_pulse_output_pin_o,  // A outputs
   input  wire logic [NUM_A-1:0]        irq_a_o,                     // A requests
   input  wire logic [NUM_B-1:0]        irq_b_o,                     // B requests
   input  wire logic [NUM_A-1:0][15:0]  read_a_o,                    // A reads
   input  wire logic [NUM_B-1:0][15:0]  read_b_o                     // B reads
);
   // one domain, so clock and reset are given once
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);
   // ============================================================
   // group A
   // ============================================================
   read_undef_a: assert property (read_a_o[0] == READ_UNDEF)
      else $error("group A read shows something else");
   halt_low_a: assert property (!count_start_i[0] [*3] |-> !group_a_pulse_output_pin_o[0])
      else $error("output high while stopped");
   irq_fall_a: assert property (irq_a_o[0] |-> $fell(group_a_pulse_output_pin_o[0]))
      else $error("request without falling output");
   irq_single_a: assert property (irq_a_o[0] |=> !irq_a_o[0])
      else $error("request longer than one cycle");
   // software one-shot rise must follow the start pulse by two edges
   sw_trig_a: assert property (($rose(group_a_pulse_output_pin_o[0]) && mode_a_i[0] == 8'h06)
      |-> $past(oneshot_start_i[0], 2))
      else $error("one-shot rise without software trigger");
   // ============================================================
   // group B
   // ============================================================
   b_irq_zero_a: assert property (irq_b_o[0] |-> $past(read_b_o[0]) == CNT_ZERO)
      else $error("group B request with nonzero counter");
   b_halt_hold_a: assert property ((!count_start_i[NUM_A] [*2] ##0 !wr_b_i[0].en)
      |=> $stable(read_b_o[0]))
      else $error("halted group B counter moved");
   b_irq_run_a: assert property (!count_start_i[NUM_A] [*4] |-> !irq_b_o[0])
      else $error("group B request while stopped");
endmodule

bind mft_timer_core mft_timer_core_sva #(.NUM_A(NUM_A), .NUM_B(NUM_B)) u_sva
(
   .clk_sys_i(clk_sys_i), .rst_i(rst_i), .count_tick_i(count_tick_i),
   .count_start_i(count_start_i), .oneshot_start_i(oneshot_start_i),
   .mode_a_i(mode_a_i), .mode_b_i(mode_b_i), .wr_a_i(wr_a_i), .wr_b_i(wr_b_i),
   .group_a_trigger_input_pin_i(group_a_trigger_input_pin_i),
   .group_b_event_input_pin_i(group_b_event_input_pin_i),
   .group_a_pulse_output_pin_o(group_a_pulse_output_pin_o), .irq_a_o(irq_a_o),
   .irq_b_o(irq_b_o), .read_a_o(read_a_o), .read_b_o(read_b_o)
);

// ==== tb/mft_pin_model.sv ====
`timescale 1ns/100ps
// ============================================================
// far side: trigger pin, event pin and count source taps
// ============================================================
module mft_pin_model
(
   input  wire logic                        clk_sys_i, // system clock
   input  wire logic                        lvl_a_i,   // wanted trigger level
   input  wire logic                        lvl_b_i,   // wanted event level
   output logic                             trig_a_o,  // trigger pin
   output logic                             event_b_o, // event pin
   output logic [mft_pkg::NUM_SRC-1:0]      tick_o     // count source taps
);
   logic [3:0] div_r; // free-running divider
   initial
   begin
      div_r = 4'h0;
      trig_a_o = 1'b0;
      event_b_o = 1'b0;
   end
   // pins move on the falling edge only, far from sampling
   always @(negedge clk_sys_i)
   begin
      div_r <= div_r + 4'h1;
      trig_a_o <= lvl_a_i;
      event_b_o <= lvl_b_i;
   end
   // tap k pulses once in 2^k cycles
   assign tick_o = {div_r[2:0] == 3'h0, div_r[1:0] == 2'h0, div_r[0], 1'b1};
endmodule

// ==== tb/multi_function_timer_oneshot_pwm_tb_top.sv ====
`timescale 1ns/100ps
module multi_function_timer_oneshot_pwm_tb_top;
   import mft_pkg::*;
   // ============================================================
   // signals
   // ============================================================
   logic                clk_sys_i, rst_i, lvl_a, lvl_b; // clock, reset, pin levels
   logic [NUM_SRC-1:0]  tick;                          // count source taps
   logic [1:0]          cs;                            // start flags A0, B0
   logic [0:0]          os, pin_a, pin_b, out_a, irq_a, irq_b; // single lanes
   logic [0:0][7:0]     mode_a, mode_b;                // mode bytes
   logic [0:0][15:0]    rd_a, rd_b;                    // read data
   mft_wr_s [0:0]       wr_a, wr_b;                    // write strobes
   int                  bad_count, checks;             // tallies
   mft_timer_core #(.NUM_A(1), .NUM_B(1)) dut
   (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .count_tick_i(tick), .count_start_i(cs),
      .oneshot_start_i(os), .mode_a_i(mode_a), .mode_b_i(mode_b), .wr_a_i(wr_a),
      .wr_b_i(wr_b), .group_a_trigger_input_pin_i(pin_a), .group_b_event_input_pin_i(pin_b),
      .group_a_pulse_output_pin_o(out_a), .irq_a_o(irq_a), .irq_b_o(irq_b),
      .read_a_o(rd_a), .read_b_o(rd_b)
   );
   mft_pin_model far (.clk_sys_i(clk_sys_i), .lvl_a_i(lvl_a), .lvl_b_i(lvl_b),
                      .trig_a_o(pin_a[0]), .event_b_o(pin_b[0]), .tick_o(tick));
   initial
   begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   // ============================================================
   // helpers
   // ============================================================
   task automatic check(input logic ok, input string msg);
      checks++;
      if (ok !== 1'b1)
      begin
         bad_count++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask
   // one-cycle write to A0 or B0
   task automatic wr(input logic b, input logic [15:0] v);
      wr_a[0].data = v;
      wr_b[0].data = v;
      wr_a[0].en = !b;
      wr_b[0].en = b;
      cyc(1);
      wr_a[0].en = 1'b0;
      wr_b[0].en = 1'b0;
   endtask
   task automatic trig();
      os[0] = 1'b1;
      cyc(1);
      os[0] = 1'b0;
   endtask
   // cycles low before a rise, cycles high, requests seen
   task automatic measure(output int w, output int hi, output int n);
      w = 0;
      hi = 0;
      n = 0;
      while (out_a[0] !== 1'b1 && w < 600)
      begin
         cyc(1);
         w++;
      end
      while (out_a[0] === 1'b1 && hi < 70000)
      begin
         cyc(1);
         hi++;
         n += int'(irq_a[0] === 1'b1);
      end
   endtask
   // cycles up to the next group B request
   task automatic gap(output int g);
      g = 0;
      do
      begin
         cyc(1);
         g++;
      end while (irq_b[0] !== 1'b1 && g < 100);
   endtask
   // ============================================================
   // scenarios
   // ============================================================
   task automatic t_oneshot();
      int w, hi, n;
      mode_a[0] = 8'h06;
      wr(1'b0, 16'h0005);
      trig();
      measure(w, hi, n);
      check(hi == 0, "trigger taken while stopped");
      cs[0] = 1'b1;
      cyc(2);
      repeat (2)
      begin
         trig();
         measure(w, hi, n);
         check(hi == 5 && n == 1, "one-shot width or request");
      end
      for (int e = 0; e < 2; e++)
      begin
         mode_a[0] = {3'h0, 1'b1, e[0], 3'h6};
         lvl_a = ~e[0];
         cyc(3);
         trig();
         measure(w, hi, n);
         check(hi == 0, "software trigger in pin mode");
         lvl_a = e[0];
         measure(w, hi, n);
         check(hi == 5, "pin edge trigger width");
         lvl_a = ~e[0];
         measure(w, hi, n);
         check(hi == 0, "wrong pin edge triggered");
      end
   endtask
   task automatic t_retrig();
      int w, hi, n;
      mode_a[0] = 8'h06;
      trig();
      wr(1'b0, 16'h0007);
      trig();
      measure(w, hi, n);
      check(hi >= 7 && hi <= 8 && n == 1, "retrigger did not reload");
      trig();
      measure(w, hi, n);
      check(hi == 7, "running write not used at reload");
      trig();
      cyc(3);
      cs[0] = 1'b0;
      cyc(3);
      check(out_a[0] === 1'b0, "stop did not force output low");
      check(rd_a[0] === READ_UNDEF, "group A read shows counter");
   endtask
   task automatic t_pwm();
      int w, hi, n;
      mode_a[0] = 8'h27;
      cyc(2);
      wr(1'b0, 16'h0301);
      cs[0] = 1'b1;
      measure(w, hi, n);
      measure(w, hi, n);
      check(hi == 6 && n == 1 && w == 504, "8-bit width or period");
      wr(1'b0, 16'h0501);
      trig();
      measure(w, hi, n);
      check(hi == 10 && w == 502, "width update or trigger ignored");
      cs[0] = 1'b0;
      mode_a[0] = 8'h1F;
      cyc(3);
      wr(1'b0, 16'h0004);
      cs[0] = 1'b1;
      cyc(4);
      check(out_a[0] === 1'b0, "modulator ran before pin edge");
      lvl_a = 1'b1;
      measure(w, hi, n);
      check(hi == 4, "16-bit width");
      cs[0] = 1'b0;
   endtask
   task automatic t_group_b();
      logic [7:0] code [4] = '{8'h01, 8'h05, 8'h09, 8'h0D};
      int exp [4] = '{1, 1, 2, 0};
      int g, n;
      mode_b[0] = 8'h00;
      wr(1'b1, 16'h0003);
      cyc(1);
      check(rd_b[0] === 16'h0003, "halted write missed counter");
      cs[1] = 1'b1;
      gap(g);
      gap(g);
      check(g == 4, "timer mode period");
      wr(1'b1, 16'h0009);
      check(rd_b[0] !== 16'h0009, "running write reached counter");
      gap(g);
      gap(g);
      check(g == 10, "period after running write");
      cs[1] = 1'b0;
      mode_b[0] = 8'h40;
      cyc(2);
      wr(1'b1, 16'h0003);
      cs[1] = 1'b1;
      gap(g);
      gap(g);
      check(g == 8, "count source select");
      for (int k = 0; k < 4; k++)
      begin
         cs[1] = 1'b0;
         mode_b[0] = code[k];
         cyc(2);
         wr(1'b1, 16'h0001);
         cs[1] = 1'b1;
         cyc(2);
         n = 0;
         repeat (4)
         begin
            lvl_b = ~lvl_b;
            repeat (3)
            begin
               cyc(1);
               n += int'(irq_b[0] === 1'b1);
            end
         end
         check(n == exp[k], "event edge choice");
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ============================================================
   // main sequence and watchdog
   // ============================================================
   initial
   begin
      rst_i = 1'b1;
      cs = 2'h0;
      os = 1'b0;
      lvl_a = 1'b0;
      lvl_b = 1'b0;
      mode_a = '0;
      mode_b = '0;
      wr_a = '0;
      wr_b = '0;
      bad_count = 0;
      checks = 0;
      repeat (6) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      rst_i = 1'b0;
      cyc(2);
      check(out_a === 1'b0 && irq_a === 1'b0 && rd_b[0] === 16'h0000, "reset state");
      t_oneshot();
      t_retrig();
      t_pwm();
      t_group_b();
      test_done();
   end
   // about 4.3k cycles expected; 30k leaves ample margin
   initial
   begin
      #300000;
      bad_count++;
      test_done();
   end
endmodule
